// ---- hdl/sbs_pkg.sv ----
package sbs_pkg;

  // Register map of the special-function space reached by the core.
  localparam logic [7:0] SBS_ADDR_DATA = 8'hf7;
  localparam logic [7:0] SBS_ADDR_CTRL = 8'hf8;
  localparam logic [7:0] SBS_DATA_RST = 8'h00;
  localparam logic [7:0] SBS_CTRL_RST = 8'h00;

  // Control register field positions.
  localparam int SBS_B_RATE_LO = 0;
  localparam int SBS_B_RATE_HI = 1;
  localparam int SBS_B_CPHA = 2;
  localparam int SBS_B_CPOL = 3;
  localparam int SBS_B_MASTER = 4;
  localparam int SBS_B_PORT_EN = 5;
  localparam int SBS_B_IRQ_EN = 6;
  localparam int SBS_B_DONE = 7;

  // Bits per byte exchange.
  localparam logic [3:0] SBS_BITS = 4'h8;

  // Register access request from the core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbs_req_t;

  // Master engine states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    SBS_IDLE = 2'b00,
    SBS_LEAD = 2'b01,
    SBS_TRAIL = 2'b11,
    SBS_DONE = 2'b10
  } sbs_state_t;

endpackage

// ---- hdl/sbs_buf2.sv ----
// Two-entry valid/ready buffer holding received bytes until the data register takes them.
module sbs_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  initial begin
    if (WIDTH < 1) $error("sbs_buf2: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_q [2];
  logic wp_q, rp_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty follow the occupancy count.
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];

  // Pointers and count advance on accepted handshakes only.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage has no reset; it is only read while valid.
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wp_q] <= in_data;
  end

endmodule

// ---- hdl/sbs_top.sv ----
// Function
// RL1: Master and slave should use identical clock polarity and phase settings.
// RL2: Data register writes queue transmit byte, reads return received byte, resets zero.
// RL3: Master drives serial clock and emits exactly eight periods per data write.
// RL4: Master ignores its own slave-select pin; software selects slaves by GPIO.
// RL5: Master shifts byte out on MOSI and samples MISO once per period.
// RL6: After eighth master clock, latch received byte, set done flag, maybe interrupt.
// RL7: External master holds slave select low for the whole byte.
// RL8: Slave takes clock as input, drives MISO and captures MOSI per period.
// RL9: Slave byte end: eighth clock with phase set, select release with clear.
// RL10: Shared two-wire pins usable only when port disabled or relocated.
// RL11: Master-select set means master driving clock, cleared means slave.
// RL12: Master rate codes 00..11 give oscillator divided by 2, 4, 8, 16.
// RL13: Phase set launches on leading edge, phase clear on trailing edge.
// RL14: In slave mode the low rate bit reads the slave-select pin level.
// RL15: Bytes shift most significant bit first in both directions.
// RL16: Done flag stays set until software clears it or interrupt vectoring.
module sbs_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire sbs_pkg::sbs_req_t req,
  output logic [7:0] rdata,
  input wire logic irq_ack,
  output logic irq,
  input wire logic relocate_pins,
  output logic two_wire_pins_free,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in
);
  import sbs_pkg::*;

  logic rst_s1_q, rst_n;
  logic [1:0] sck_sync_q, mosi_sync_q, miso_sync_q, ss_sync_q;
  logic sck_d1_q, ss_d1_q;
  logic [7:0] data_q, ctrl_q, tx_q, rx_q;
  logic [3:0] bits_q;
  logic [3:0] div_q;
  logic sck_q, slv_busy_q, slv_last_q;
  logic [1:0] m_take_q;
  sbs_state_t st_q;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Pin inputs pass two flip-flops; only the second stage is read.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync_q <= 2'b00;
      mosi_sync_q <= 2'b00;
      miso_sync_q <= 2'b00;
      ss_sync_q <= 2'b11;
      sck_d1_q <= 1'b0;
      ss_d1_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clock_pin_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
      miso_sync_q <= {miso_sync_q[0], miso_in};
      ss_sync_q <= {ss_sync_q[0], ss_n_in};
      sck_d1_q <= sck_sync_q[1];
      ss_d1_q <= ss_sync_q[1];
    end
  end

  // Control decode.
  wire en = ctrl_q[SBS_B_PORT_EN];
  wire master = ctrl_q[SBS_B_MASTER]; // RL11
  wire cpha = ctrl_q[SBS_B_CPHA];
  wire cpol = ctrl_q[SBS_B_CPOL];
  wire [1:0] rate = {ctrl_q[SBS_B_RATE_HI], ctrl_q[SBS_B_RATE_LO]};
  wire wr_data = req.wr && req.addr == SBS_ADDR_DATA;
  wire wr_ctrl = req.wr && req.addr == SBS_ADDR_CTRL;
  // Half period in clocks: 1, 2, 4, 8 so the full period is 2, 4, 8, 16.
  wire [3:0] half = 4'h1 << rate; // RL12
  wire div_hit = (div_q == half - 4'h1);

  // Slave edge detection on the synchronised clock, gated by select.
  wire ss_act = !ss_sync_q[1];
  wire sck_r = sck_sync_q[1] && !sck_d1_q;
  wire sck_f = !sck_sync_q[1] && sck_d1_q;
  wire lead = cpol ? sck_f : sck_r;
  wire trail = cpol ? sck_r : sck_f;
  wire slv_on = en && !master && ss_act; // RL8
  wire slv_sample = slv_on && (cpha ? trail : lead); // RL13
  wire slv_shift = slv_on && (cpha ? lead : trail)
                   && (cpha ? bits_q != 4'h0 : bits_q != SBS_BITS); // RL13
  wire ss_rise = ss_sync_q[1] && !ss_d1_q;
  // Byte end: the clock after the eighth sample with phase set, so the last bit is
  // already in the shift register; select release with phase clear.
  wire slv_last = slv_sample && cpha && bits_q == 4'h7;
  wire slv_end = en && !master && (cpha ? slv_last_q : (ss_rise && bits_q == SBS_BITS)); // RL9

  // Master timing: leading edge samples or launches depending on phase.
  wire m_edge = en && master && (st_q == SBS_LEAD || st_q == SBS_TRAIL) && div_hit;
  wire m_sample = m_edge && (st_q == (cpha ? SBS_TRAIL : SBS_LEAD)); // RL5 RL13
  // With phase set the first bit stands before the first launch edge, so that launch does not shift it away.
  wire m_shift = m_edge && (st_q == (cpha ? SBS_LEAD : SBS_TRAIL))
                 && (cpha ? bits_q != 4'h0 : bits_q != SBS_BITS); // RL13
  // Last period: the eighth sample is taken now (phase set) or was taken already.
  wire m_last = (bits_q == (cpha ? SBS_BITS - 4'h1 : SBS_BITS)); // RL3
  // Completion waits until the delayed sample pipeline has emptied.
  wire m_end = en && master && st_q == SBS_DONE && m_take_q == 2'b00; // RL6
  wire rx_bit = master ? miso_sync_q[1] : mosi_sync_q[1];
  wire byte_end = m_end || slv_end;

  // Received bytes pass through a two-entry buffer into the data register.
  wire rxb_out_valid;
  wire [7:0] rxb_out_data;
  wire rxb_in_ready;
  sbs_buf2 #(.WIDTH(8)) u_rxbuf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(byte_end),
    .in_ready(rxb_in_ready),
    .in_data(rx_q),
    .out_valid(rxb_out_valid),
    .out_ready(!wr_data),
    .out_data(rxb_out_data)
  );

  // Master engine: idle, clock phases per bit, then completion.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SBS_IDLE;
      div_q <= 4'h0;
      sck_q <= 1'b0;
      m_take_q <= 2'b00;
    end else if (!(en && master)) begin
      st_q <= SBS_IDLE;
      div_q <= 4'h0;
      sck_q <= 1'b0;
      m_take_q <= 2'b00;
    end else begin
      div_q <= (st_q == SBS_IDLE || div_hit) ? 4'h0 : div_q + 4'h1;
      m_take_q <= {m_take_q[0], m_sample}; // RL5
      case (st_q)
        SBS_IDLE: if (wr_data && rxb_in_ready) st_q <= SBS_LEAD; // RL3
        SBS_LEAD: if (div_hit) begin
          st_q <= SBS_TRAIL;
          sck_q <= 1'b1;
        end
        SBS_TRAIL: if (div_hit) begin
          sck_q <= 1'b0;
          st_q <= m_last ? SBS_DONE : SBS_LEAD; // RL3
        end
        SBS_DONE: if (m_take_q == 2'b00) st_q <= SBS_IDLE;
        default: st_q <= SBS_IDLE;
      endcase
    end
  end

  // Shift registers, MSB first; bit count counts samples.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= SBS_DATA_RST;
      rx_q <= SBS_DATA_RST;
      bits_q <= 4'h0;
      slv_busy_q <= 1'b0;
      slv_last_q <= 1'b0;
    end else begin
      slv_last_q <= slv_last;
      if (wr_data) begin
        tx_q <= req.wdata; // RL2
        if (!slv_busy_q && st_q == SBS_IDLE) bits_q <= 4'h0;
      end else if (m_sample || slv_sample) begin
        bits_q <= bits_q + 4'h1;
      end
      // Master bits enter two clocks after their edge, once the pin synchroniser has them.
      if (m_take_q[1] || slv_sample) rx_q <= {rx_q[6:0], rx_bit}; // RL5 RL15
      if (m_shift || slv_shift) tx_q <= {tx_q[6:0], 1'b0}; // RL15
      if (slv_on) slv_busy_q <= 1'b1;
      if (byte_end || ss_rise || master) begin
        slv_busy_q <= 1'b0;
        if (slv_end || (ss_rise && !master)) bits_q <= 4'h0; // RL4
      end
    end
  end

  // Data and control registers; done flag set wins over its clears.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= SBS_DATA_RST; // RL2
      ctrl_q <= SBS_CTRL_RST;
    end else begin
      if (wr_data) data_q <= req.wdata;
      else if (rxb_out_valid) data_q <= rxb_out_data; // RL6 RL9
      if (wr_ctrl) ctrl_q <= req.wdata;
      if (irq_ack) ctrl_q[SBS_B_DONE] <= 1'b0; // RL16
      if (byte_end) ctrl_q[SBS_B_DONE] <= 1'b1; // RL6 RL9
    end
  end

  // Read mux: slave mode shows select level in low rate bit.
  wire [7:0] ctrl_rd = (!master) ? {ctrl_q[7:1], ss_sync_q[1]} : ctrl_q; // RL14
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (req.rd) rdata <= (req.addr == SBS_ADDR_DATA) ? data_q :
                             (req.addr == SBS_ADDR_CTRL) ? ctrl_rd : 8'h00;
  end

  // Pin drive; own select is ignored in master mode.
  assign irq = ctrl_q[SBS_B_DONE] && ctrl_q[SBS_B_IRQ_EN]; // RL6
  assign serial_clock_pin_out = sck_q ^ cpol; // RL1
  assign serial_clock_pin_oe = en && master; // RL3 RL4
  assign mosi_out = tx_q[7];
  assign mosi_oe = en && master; // RL5
  assign miso_out = tx_q[7];
  assign miso_oe = en && !master && ss_act; // RL8
  assign two_wire_pins_free = !en || relocate_pins; // RL10

  property p_rl3_oe;
    @(posedge clk_sys) disable iff (!rst_n)
      m_end |-> serial_clock_pin_oe && bits_q == SBS_BITS;
  endproperty
  a_rl3_oe: assert property (p_rl3_oe) else $error("master burst not eight periods"); // RL3

  property p_rl6_done;
    @(posedge clk_sys) disable iff (!rst_n)
      m_end |=> ctrl_q[SBS_B_DONE];
  endproperty
  a_rl6_done: assert property (p_rl6_done) else $error("done flag not set"); // RL6

  property p_rl9_done;
    @(posedge clk_sys) disable iff (!rst_n)
      slv_end |=> ctrl_q[SBS_B_DONE];
  endproperty
  a_rl9_done: assert property (p_rl9_done) else $error("slave done not set"); // RL9

  property p_rl8_miso;
    @(posedge clk_sys) disable iff (!rst_n)
      (master || !en) |-> !miso_oe;
  endproperty
  a_rl8_miso: assert property (p_rl8_miso) else $error("miso driven out of slave"); // RL8

  property p_rl10_pins;
    @(posedge clk_sys) disable iff (!rst_n)
      (en && !relocate_pins) |-> !two_wire_pins_free;
  endproperty
  a_rl10_pins: assert property (p_rl10_pins) else $error("shared pins released"); // RL10

  property p_rl16_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl_q[SBS_B_DONE] && !irq_ack && !wr_ctrl) |=> ctrl_q[SBS_B_DONE];
  endproperty
  a_rl16_hold: assert property (p_rl16_hold) else $error("done flag dropped"); // RL16

  property p_rl12_div;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == SBS_LEAD && $past(st_q) == SBS_IDLE && rate == 2'b11)
        |-> (st_q == SBS_LEAD) [*8];
  endproperty
  a_rl12_div: assert property (p_rl12_div) else $error("half period wrong"); // RL12

  property p_rl2_wr;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_data |=> data_q == $past(req.wdata);
  endproperty
  a_rl2_wr: assert property (p_rl2_wr) else $error("data write lost"); // RL2

endmodule

// ---- tb/sbs_slave_model.sv ----
// Far-side serial peripheral answering the block while it runs as master.
module sbs_slave_model (
  input wire logic sclk,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh = '0;
  logic lead;
  // With phase set a dummy bit leads, so the first leading edge launches bit 7.
  always @(negedge sel_n) sh = cpha ? {~tx[7], tx} : {tx, 1'b0};
  // A released line shows the inverse of its last value.
  always @(posedge sel_n) sh[8] = ~sh[8];
  // Launch on one edge, sample on the other, as the phase setting picks.
  always @(sclk) begin
    lead = (sclk != cpol);
    if (!sel_n && (lead == cpha)) sh = {sh[7:0], 1'b0};
    if (!sel_n && (lead != cpha)) rx = {rx[6:0], mosi};
  end
  assign miso = sh[8];
endmodule

// ---- tb/tb.sv ----
// Self-checking bench: master transfers in every mode and rate, then two slave bytes.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;
  typedef struct packed {
    logic [1:0] rate;
    logic pol;
    logic pha;
    logic [7:0] tx;
    logic [7:0] mtx;
  } sbs_tb_row_t;
  logic clk_sys = 1'b0, rstn = 1'b0, irq_ack = 1'b0, relocate_pins = 1'b0, ss_n_in = 1'b1;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, sel_n = 1'b1, cpol = 1'b0, cpha = 1'b0, prev;
  sbs_req_t req = '0;
  logic irq, pins_free, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, m_miso;
  logic [7:0] rdata, m_rx, m_tx, d, cap, sv;
  int failures = 0, checks_done = 0, hi, edges;
  sbs_tb_row_t r;
  sbs_tb_row_t rows[4] = '{'{2'h0, 1'b0, 1'b0, 8'h96, 8'h5a}, '{2'h1, 1'b0, 1'b1, 8'h81, 8'h7e},
    '{2'h2, 1'b1, 1'b0, 8'h01, 8'hc3}, '{2'h3, 1'b1, 1'b1, 8'hf0, 8'h0f}};
  // Shared lines resolve from whichever side enables its driver.
  wire sck = sck_oe ? sck_out : tb_sck;
  wire mosi = mosi_oe ? mosi_out : tb_mosi;
  wire miso = miso_oe ? miso_out : m_miso;
  always #20 clk_sys = ~clk_sys;
  sbs_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata), .irq_ack(irq_ack),
    .irq(irq), .relocate_pins(relocate_pins), .two_wire_pins_free(pins_free),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
    .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
  sbs_slave_model i_peer (.sclk(sck), .cpol(cpol), .cpha(cpha), .sel_n(sel_n), .mosi(mosi),
    .tx(m_tx), .miso(m_miso), .rx(m_rx));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk_sys) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys) req = '0;
    v = rdata;
  endtask
  task automatic wrap_up();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short well after the expected run length.
  initial begin
    #300000;
    failures++;
    wrap_up();
  end
  // Main sequence: reset values, the table of master transfers, then the hand-written cases.
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(SBS_ADDR_DATA, d);
    chk(d, SBS_DATA_RST);
    rd(SBS_ADDR_CTRL, d);
    chk(d, {SBS_CTRL_RST[7:1], 1'b1});
    rd(8'h10, d);
    chk(d, 8'h00);
    chk({7'h0, pins_free}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      cpol = r.pol;
      cpha = r.pha;
      m_tx = r.mtx;
      ss_n_in = r.pha;
      wr(SBS_ADDR_CTRL, {4'h7, r.pol, r.pha, r.rate});
      chk({7'h0, pins_free}, 8'h00);
      sel_n = 1'b0;
      wr(SBS_ADDR_DATA, r.tx);
      hi = 0;
      edges = 0;
      prev = sck_out;
      for (int n = 0; n < 600 && irq !== 1'b1; n++) begin
        @(negedge clk_sys);
        hi += (sck_out !== r.pol);
        edges += (sck_out !== prev);
        prev = sck_out;
      end
      chk({6'h0, sck_oe, mosi_oe}, 8'h03);
      chk(edges[7:0], 8'd16);
      chk(hi[7:0], 8'd8 << r.rate);
      repeat (4) @(negedge clk_sys);
      sel_n = 1'b1;
      chk(m_rx, r.tx);
      rd(SBS_ADDR_DATA, d);
      chk(d, r.mtx);
      rd(SBS_ADDR_CTRL, d);
      chk({7'h0, d[7]}, 8'h01);
      chk({7'h0, irq}, 8'h01);
      @(negedge clk_sys) irq_ack = 1'b1;
      @(negedge clk_sys) irq_ack = 1'b0;
      @(negedge clk_sys) chk({7'h0, irq}, 8'h00);
    end
    relocate_pins = 1'b1;
    @(negedge clk_sys) chk({7'h0, pins_free}, 8'h01);
    // Slave byte with phase set; the select pin level reads back in the low rate bit.
    wr(SBS_ADDR_CTRL, 8'h64);
    wr(SBS_ADDR_DATA, 8'ha5);
    ss_n_in = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(SBS_ADDR_CTRL, d);
    chk({7'h0, d[0]}, 8'h01);
    ss_n_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(SBS_ADDR_CTRL, d);
    chk({7'h0, d[0]}, 8'h00);
    chk({6'h0, sck_oe, miso_oe}, 8'h01);
    sv = 8'h3c;
    for (int b = 7; b >= 0; b--) begin
      tb_sck = 1'b1;
      tb_mosi = sv[b];
      repeat (8) @(negedge clk_sys);
      cap = {cap[6:0], miso_out};
      tb_sck = 1'b0;
      repeat (8) @(negedge clk_sys);
    end
    chk({7'h0, irq}, 8'h01);
    rd(SBS_ADDR_DATA, d);
    chk(d, sv);
    chk(cap, 8'ha5);
    // Slave byte with phase clear: the byte only ends when the select goes high again.
    ss_n_in = 1'b1;
    wr(SBS_ADDR_CTRL, 8'h60);
    wr(SBS_ADDR_DATA, 8'h69);
    ss_n_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    sv = 8'hd2;
    for (int b = 7; b >= 0; b--) begin
      tb_mosi = sv[b];
      repeat (8) @(negedge clk_sys);
      cap = {cap[6:0], miso_out};
      tb_sck = 1'b1;
      repeat (8) @(negedge clk_sys);
      tb_sck = 1'b0;
      repeat (8) @(negedge clk_sys);
    end
    chk({7'h0, irq}, 8'h00);
    ss_n_in = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk({7'h0, irq}, 8'h01);
    rd(SBS_ADDR_DATA, d);
    chk(d, sv);
    chk(cap, 8'h69);
    wrap_up();
  end
endmodule
